// ===== rtl/tco_pkg.sv
// constants, carriers and enumerations of the triggered channel output control
// Function
// [RULE1] ten banks of twelve, two sections, 120 channels
// [RULE2] per-bank select: high-voltage pair or low-voltage pair
// [RULE3] each channel is high, low or off
// [RULE4] bank n owns channels 12(n-1)+1 to 12n
// [RULE5] over-current turns channel off, sticky event recorded
// [RULE6] per-channel enable bit and per-channel level bit
// [RULE7] per-channel comparator readback register
// [RULE8] per-bank 12-bit threshold DAC code, 0 to 4095
// [RULE9] outside trigger mode enable/level apply at once
// [RULE10] in trigger mode enable/level wait for trigger
// [RULE11] only enable and level are trigger gated
// [RULE12] software sets trigger sources before relying on them
// [RULE13] sources: two external, eight backplane lines, software
// [RULE14] external AND needs both high, OR either
// [RULE15] external inputs are active-high level triggers
// [RULE16] backplane lines edge sensitive, rising or falling selectable
// [RULE17] backplane edge used only when external not enabled
// [RULE18] software trigger bit fires, applying pending changes
// [RULE19] priority external, then backplane, then software
// [RULE20] all pending changes applied in one cycle
package tco_pkg;
	localparam int NUM_BANKS      = 10;
	localparam int CH_PER_BANK    = 12;
	localparam int BANKS_PER_SECT = 5;
	localparam int NUM_SECTS      = 2;
	localparam int NUM_CH         = NUM_BANKS * CH_PER_BANK;
	localparam int NUM_WORDS      = 4;
	localparam int DAC_W          = 12;
	localparam int NUM_TTL        = 8;
	localparam int ADDR_W         = 8;
	localparam int SYNC_W         = 2 + NUM_TTL + 2 * NUM_CH;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_BANKV = 8'h04;
	localparam logic [7:0] OFF_ENA   = 8'h10;
	localparam logic [7:0] OFF_LVL   = 8'h20;
	localparam logic [7:0] OFF_OCS   = 8'h30;
	localparam logic [7:0] OFF_RDB   = 8'h40;
	localparam logic [7:0] OFF_ACT   = 8'h50;
	localparam logic [7:0] OFF_DAC   = 8'h80;

	// trigger control field positions
	localparam int CTRL_TMODE    = 0;
	localparam int CTRL_EXT_EN   = 1;
	localparam int CTRL_EXT_AND  = 2;
	localparam int CTRL_TTL_EN   = 3;
	localparam int CTRL_TTL_RISE = 4;
	localparam int CTRL_SW_EN    = 5;
	localparam int CTRL_TTL_LSB  = 8;
	localparam int CTRL_SW_FIRE  = 31;

	localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_FF3F;
	localparam logic [31:0] TOP_MASK   = 32'h00FF_FFFF;
	localparam logic [31:0] WORD_MASK  = 32'hFFFF_FFFF;
	localparam logic [9:0]  BANKV_RST  = 10'h000;
	localparam logic [11:0] DAC_RST    = 12'h000;
	localparam logic [11:0] DAC_FULL   = 12'hFFF;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {TRIG_NONE, TRIG_EXT, TRIG_TTL, TRIG_SW} tco_trig_e;

	typedef logic [NUM_WORDS-1:0][31:0] tco_words_t;

	// per-channel drive towards the output stage
	typedef struct packed {
		logic [NUM_CH-1:0] on;
		logic [NUM_CH-1:0] high;
		logic [NUM_CH-1:0] hv;
	} tco_drive_s;

	// per-bank settings towards the analog side
	typedef struct packed {
		logic [NUM_BANKS-1:0]            hv;
		logic [NUM_BANKS-1:0][DAC_W-1:0] dac;
	} tco_bank_s;
endpackage

// ===== rtl/tco_top.sv
// triggered channel output control with AXI4-Lite register slave
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tco_top (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write address
	input  wire logic [tco_pkg::ADDR_W-1:0]  awaddr,
	input  wire logic [2:0]                  awprot,
	input  wire logic                        awvalid,
	output logic                             awready,
	// axi4-lite write data
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	// axi4-lite write response
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	// axi4-lite read address
	input  wire logic [tco_pkg::ADDR_W-1:0]  araddr,
	input  wire logic [2:0]                  arprot,
	input  wire logic                        arvalid,
	output logic                             arready,
	// axi4-lite read data
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	// trigger pins
	input  wire logic                        external_trigger_a,
	input  wire logic                        external_trigger_b,
	input  wire logic [tco_pkg::NUM_TTL-1:0] ttl_trig,
	// analog side
	input  wire logic [tco_pkg::NUM_CH-1:0]  oc_in,
	input  wire logic [tco_pkg::NUM_CH-1:0]  cmp_in,
	output tco_pkg::tco_drive_s              drive,
	output tco_pkg::tco_bank_s               bank
);
	import tco_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{s[b]}};
		end
		return m;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] s);
		return (old & ~strb_mask(s)) | (wd & strb_mask(s));
	endfunction

	// top word holds channels 96..119 only
	function automatic logic [31:0] word_mask(input logic [1:0] idx);
		return (idx == 2'(NUM_WORDS - 1)) ? TOP_MASK : WORD_MASK;
	endfunction

	function automatic logic dac_hit(input logic [ADDR_W-1:0] a);
		return (a[7:6] == OFF_DAC[7:6]) && (a[5:2] < 4'(NUM_BANKS));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// state

	logic [SYNC_W-1:0]          sy1_q, sy2_q, sy3_q, flt_q, flt_d;
	logic [NUM_TTL-1:0]         ttl_prev_q;
	logic [31:0]                ctrl_q, ctrl_d;
	logic [NUM_BANKS-1:0]       bankv_q, bankv_d;
	logic [NUM_BANKS-1:0][DAC_W-1:0] dac_q, dac_d;
	tco_words_t                 pend_on_q, pend_on_d, pend_hi_q, pend_hi_d;
	tco_words_t                 act_on_q, act_on_d, act_hi_q, act_hi_d;
	tco_words_t                 ocs_q, ocs_d;
	logic                       aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [ADDR_W-1:0]          awaddr_q, awaddr_d;
	logic [31:0]                wdata_q, wdata_d;
	logic [3:0]                 wstrb_q, wstrb_d;
	logic                       bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]                 bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0]                rdata_q, rdata_d;

	logic                       ext_a, ext_b, ext_lvl, ttl_edge, sw_fire, fire, wr_go;
	logic [NUM_TTL-1:0]         ttl_f;
	logic [NUM_CH-1:0]          oc_f, cmp_f, act_on_w, act_hi_w, ocs_w;
	tco_words_t                 oc_words, cmp_words;
	tco_trig_e                  trig_src;
	logic [1:0]                 widx, ridx;
	logic [3:0]                 didx, rdidx;
	logic [31:0]                bank_m, dac_m;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stages two and three agree

	assign flt_d = (~(sy2_q ^ sy3_q) & sy3_q) | ((sy2_q ^ sy3_q) & flt_q);

	assign {cmp_f, oc_f, ttl_f, ext_b, ext_a} = flt_q;
	assign oc_words  = {8'h00, oc_f};
	assign cmp_words = {8'h00, cmp_f};

	////////////////////////////////////////////////////////////////////////////////
	// trigger selection

	assign ext_lvl  = ctrl_q[CTRL_EXT_AND] ? (ext_a & ext_b) : (ext_a | ext_b); // see [RULE14] [RULE15]
	assign ttl_edge = |((ctrl_q[CTRL_TTL_RISE] ? (ttl_f & ~ttl_prev_q) : (~ttl_f & ttl_prev_q))
		& ctrl_q[CTRL_TTL_LSB +: NUM_TTL]); // see [RULE16]

	always_comb begin
		// highest enabled source alone is honoured
		if (ctrl_q[CTRL_EXT_EN]) begin // see [RULE19] [RULE13]
			trig_src = TRIG_EXT;
		end else if (ctrl_q[CTRL_TTL_EN]) begin // see [RULE17]
			trig_src = TRIG_TTL;
		end else if (ctrl_q[CTRL_SW_EN]) begin
			trig_src = TRIG_SW;
		end else begin
			trig_src = TRIG_NONE;
		end
		case (trig_src)
			TRIG_EXT: fire = ext_lvl;
			TRIG_TTL: fire = ttl_edge;
			TRIG_SW:  fire = sw_fire; // see [RULE18]
			default:  fire = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus handshake outputs

	assign awready = !aw_got_q && !bvalid_q;
	assign wready  = !w_got_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign wr_go   = aw_got_q && w_got_q;
	assign widx    = awaddr_q[3:2];
	assign didx    = awaddr_q[5:2];
	assign ridx    = araddr[3:2];
	assign rdidx   = araddr[5:2];
	assign sw_fire = wr_go && (awaddr_q == OFF_CTRL) && wstrb_q[3] && wdata_q[CTRL_SW_FIRE];
	assign bank_m  = merge({22'h0, bankv_q}, wdata_q, wstrb_q);
	assign dac_m   = merge({20'h0, dac_q[didx]}, wdata_q, wstrb_q);

	////////////////////////////////////////////////////////////////////////////////
	// next-state logic

	always_comb begin
		aw_got_d  = aw_got_q | (awvalid & awready);
		w_got_d   = w_got_q | (wvalid & wready);
		awaddr_d  = (awvalid & awready) ? awaddr : awaddr_q;
		wdata_d   = (wvalid & wready) ? wdata : wdata_q;
		wstrb_d   = (wvalid & wready) ? wstrb : wstrb_q;
		bvalid_d  = bvalid_q & ~bready;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q & ~rready;
		rresp_d   = rresp_q;
		rdata_d   = rdata_q;
		ctrl_d    = ctrl_q;
		bankv_d   = bankv_q;
		dac_d     = dac_q;
		pend_on_d = pend_on_q;
		pend_hi_d = pend_hi_q;
		act_on_d  = act_on_q;
		act_hi_d  = act_hi_q;
		ocs_d     = ocs_q;

		// register writes
		if (wr_go) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = RESP_OKAY;
			if (awaddr_q == OFF_CTRL) begin
				ctrl_d = merge(ctrl_q, wdata_q, wstrb_q) & CTRL_WMASK;
			end else if (awaddr_q == OFF_BANKV) begin
				bankv_d = bank_m[NUM_BANKS-1:0]; // see [RULE2] [RULE11]
			end else if (awaddr_q[7:4] == OFF_ENA[7:4]) begin
				pend_on_d[widx] = merge(pend_on_q[widx], wdata_q, wstrb_q)
					& word_mask(widx); // see [RULE6]
			end else if (awaddr_q[7:4] == OFF_LVL[7:4]) begin
				pend_hi_d[widx] = merge(pend_hi_q[widx], wdata_q, wstrb_q)
					& word_mask(widx); // see [RULE6]
			end else if (awaddr_q[7:4] == OFF_OCS[7:4]) begin
				ocs_d[widx] = ocs_q[widx] & ~(wdata_q & strb_mask(wstrb_q));
			end else if (awaddr_q[7:4] == OFF_RDB[7:4] || awaddr_q[7:4] == OFF_ACT[7:4]) begin
				bresp_d = RESP_OKAY;
			end else if (dac_hit(awaddr_q)) begin
				dac_d[didx] = dac_m[DAC_W-1:0]; // see [RULE8] [RULE11]
			end else begin
				bresp_d = RESP_SLVERR;
			end
		end

		// pending enable and level move to the outputs together
		if (!ctrl_q[CTRL_TMODE] || fire) begin // see [RULE9] [RULE10] [RULE20]
			act_on_d = pend_on_d;
			act_hi_d = pend_hi_d;
		end

		// over-current shuts the channel and sets the sticky event, set beats clear
		pend_on_d = pend_on_d & ~oc_words; // see [RULE5]
		act_on_d  = act_on_d & ~oc_words;  // see [RULE5]
		ocs_d     = ocs_d | oc_words;      // see [RULE5]

		// register reads
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rresp_d  = RESP_OKAY;
			if (araddr == OFF_CTRL) begin
				rdata_d = ctrl_q;
			end else if (araddr == OFF_BANKV) begin
				rdata_d = {22'h0, bankv_q};
			end else if (araddr[7:4] == OFF_ENA[7:4]) begin
				rdata_d = pend_on_q[ridx];
			end else if (araddr[7:4] == OFF_LVL[7:4]) begin
				rdata_d = pend_hi_q[ridx];
			end else if (araddr[7:4] == OFF_OCS[7:4]) begin
				rdata_d = ocs_q[ridx];
			end else if (araddr[7:4] == OFF_RDB[7:4]) begin
				rdata_d = cmp_words[ridx]; // see [RULE7]
			end else if (araddr[7:4] == OFF_ACT[7:4]) begin
				rdata_d = act_on_q[ridx];
			end else if (dac_hit(araddr)) begin
				rdata_d = {20'h0, dac_q[rdidx]};
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = RESP_SLVERR;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy1_q      <= '0;
			sy2_q      <= '0;
			sy3_q      <= '0;
			flt_q      <= '0;
			ttl_prev_q <= '0;
			ctrl_q     <= CTRL_RST;
			bankv_q    <= BANKV_RST;
			dac_q      <= {NUM_BANKS{DAC_RST}};
			pend_on_q  <= '0;
			pend_hi_q  <= '0;
			act_on_q   <= '0;
			act_hi_q   <= '0;
			ocs_q      <= '0;
			aw_got_q   <= 1'b0;
			w_got_q    <= 1'b0;
			awaddr_q   <= '0;
			wdata_q    <= '0;
			wstrb_q    <= '0;
			bvalid_q   <= 1'b0;
			bresp_q    <= RESP_OKAY;
			rvalid_q   <= 1'b0;
			rresp_q    <= RESP_OKAY;
			rdata_q    <= '0;
		end else begin
			sy1_q      <= {cmp_in, oc_in, ttl_trig, external_trigger_b, external_trigger_a};
			sy2_q      <= sy1_q;
			sy3_q      <= sy2_q;
			flt_q      <= flt_d;
			ttl_prev_q <= ttl_f;
			ctrl_q     <= ctrl_d;
			bankv_q    <= bankv_d;
			dac_q      <= dac_d;
			pend_on_q  <= pend_on_d;
			pend_hi_q  <= pend_hi_d;
			act_on_q   <= act_on_d;
			act_hi_q   <= act_hi_d;
			ocs_q      <= ocs_d;
			aw_got_q   <= aw_got_d;
			w_got_q    <= w_got_d;
			awaddr_q   <= awaddr_d;
			wdata_q    <= wdata_d;
			wstrb_q    <= wstrb_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rresp_q    <= rresp_d;
			rdata_q    <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign bvalid   = bvalid_q;
	assign bresp    = bresp_q;
	assign rvalid   = rvalid_q;
	assign rresp    = rresp_q;
	assign rdata    = rdata_q;
	assign act_on_w = NUM_CH'(act_on_q);
	assign act_hi_w = NUM_CH'(act_hi_q);
	assign ocs_w    = NUM_CH'(ocs_q);

	assign drive.on   = act_on_w; // see [RULE3]
	assign drive.high = act_hi_w; // see [RULE3]
	assign bank.hv    = bankv_q;
	assign bank.dac   = dac_q;

	// bank n drives channels 12n..12n+11, sections are banks 0-4 and 5-9
	for (genvar c = 0; c < NUM_CH; c++) begin : g_chan_bank
		assign drive.hv[c] = bankv_q[c / CH_PER_BANK]; // see [RULE1] [RULE4]
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_oc_shut_off: assert property ((oc_f != '0) |=> ((act_on_w & $past(oc_f)) == '0)) // see [RULE5]
		else $error("channel stays on after over-current");
	a_oc_event_set: assert property ((oc_f != '0) |=> ((ocs_w & $past(oc_f)) == $past(oc_f))) // see [RULE5]
		else $error("over-current event not recorded");
	a_direct_apply: assert property (
		(!ctrl_q[CTRL_TMODE] && oc_f == '0) |=> (act_hi_q == $past(pend_hi_d))) // see [RULE9]
		else $error("level not applied outside trigger mode");
	a_hold_pending: assert property ((ctrl_q[CTRL_TMODE] && !fire)
		|=> (act_hi_q == $past(act_hi_q))) // see [RULE10]
		else $error("level changed without a trigger");
	a_trig_apply: assert property ((ctrl_q[CTRL_TMODE] && fire && oc_f == '0)
		|=> (act_on_q == $past(pend_on_d) && act_hi_q == $past(pend_hi_d))) // see [RULE20]
		else $error("pending state not applied on trigger");
	a_ext_prio: assert property ((ctrl_q[CTRL_EXT_EN] && !ext_lvl) |-> !fire) // see [RULE19]
		else $error("lower source honoured while external enabled");
	a_ext_and: assert property ((ctrl_q[CTRL_EXT_EN] && ctrl_q[CTRL_EXT_AND] && ext_a && !ext_b)
		|-> !fire) // see [RULE14]
		else $error("and mode fired on one input");
	a_ext_level: assert property ((ctrl_q[CTRL_EXT_EN] && ext_a && ext_b)[*3] |-> fire) // see [RULE15]
		else $error("held external level stopped firing");
	a_ttl_edge: assert property ((!ctrl_q[CTRL_EXT_EN] && ctrl_q[CTRL_TTL_EN] && ttl_edge)
		|-> fire) // see [RULE16] [RULE17]
		else $error("backplane edge ignored");
	a_sw_fire: assert property ((ctrl_q[5:1] == 5'h10 && sw_fire) |-> fire) // see [RULE18]
		else $error("software trigger ignored");
	a_bank_hv: assert property (drive.hv[23:12] == {CH_PER_BANK{bankv_q[1]}}) // see [RULE4]
		else $error("second bank channel map wrong");
	a_rd_answer: assert property ((arvalid && arready) |=> rvalid)
		else $error("read not answered");
	a_rd_hold: assert property ((rvalid && !rready)
		|=> (rvalid && $stable(rdata) && $stable(rresp)))
		else $error("read answer dropped early");
	a_wr_answer: assert property ((aw_got_q && w_got_q) |=> bvalid)
		else $error("write not answered");
	a_wr_hold: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
		else $error("write answer dropped early");
	a_bankv_now: assert property ((wr_go && awaddr_q == OFF_BANKV && wstrb_q == 4'hF) // see [RULE11]
		|=> (bankv_q == $past(wdata_q[NUM_BANKS-1:0])))
		else $error("bank select held back");
	a_direct_on: assert property ((!ctrl_q[CTRL_TMODE] && oc_f == '0) // see [RULE9]
		|=> (act_on_q == $past(pend_on_d)))
		else $error("enable not applied outside trigger mode");
	a_tmode_on: assert property ((ctrl_q[CTRL_TMODE] && !fire && oc_f == '0) // see [RULE10]
		|=> (act_on_q == $past(act_on_q)))
		else $error("enable changed without a trigger");
	a_pend_oc: assert property ((oc_f != '0) // see [RULE5]
		|=> ((pend_on_q & $past(oc_words)) == '0))
		else $error("pending enable kept after over-current");
	a_ocs_sticky: assert property ((ocs_q != '0 && !wr_go) // see [RULE5]
		|=> ((ocs_q & $past(ocs_q)) == $past(ocs_q)))
		else $error("over-current event lost");
	a_ttl_blocked: assert property ((ctrl_q[CTRL_EXT_EN] && !ext_lvl && ttl_edge) // see [RULE17]
		|-> !fire)
		else $error("backplane edge honoured while external enabled");
	a_top_unused: assert property (act_on_q[NUM_WORDS-1][31:24] == 8'h00) // see [RULE1]
		else $error("enable beyond last channel");
endmodule
`default_nettype wire

// ===== tb/tco_far_model.sv
// trigger sources and analog feedback pins beside the output control
`timescale 1ns/1ps
`default_nettype none
module tco_far_model (
	// clock
	input  wire logic                        aclk,
	// trigger sources
	output logic                             external_trigger_a,
	output logic                             external_trigger_b,
	output logic [tco_pkg::NUM_TTL-1:0]      ttl_trig,
	// analog feedback
	output logic [tco_pkg::NUM_CH-1:0]       oc_in,
	output logic [tco_pkg::NUM_CH-1:0]       cmp_in
);
	import tco_pkg::*;
	initial begin
		external_trigger_a = 1'b0;
		external_trigger_b = 1'b0;
		ttl_trig           = '0;
		oc_in              = '0;
		cmp_in             = '0;
	end
	// levels change on a clock edge; callers hold them 180 ns or more
	task automatic set_ext(input logic a, input logic b);
		@(posedge aclk);
		external_trigger_a <= a;
		external_trigger_b <= b;
	endtask
	task automatic set_ttl(input logic [NUM_TTL-1:0] v);
		@(posedge aclk);
		ttl_trig <= v;
	endtask
	task automatic set_oc(input logic [NUM_CH-1:0] v);
		@(posedge aclk);
		oc_in <= v;
	endtask
	task automatic set_cmp(input logic [NUM_CH-1:0] v);
		@(posedge aclk);
		cmp_in <= v;
	endtask
endmodule
`default_nettype wire

// ===== tb/triggered_channel_output_control_tb.sv
// self-checking bench of the triggered channel output control
`timescale 1ns/1ps
`default_nettype none
module triggered_channel_output_control_tb;
	import tco_pkg::*;
	logic              aclk;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr  = '0;
	logic              awvalid = 1'b0;
	logic              awready;
	logic [31:0]       wdata   = '0;
	logic              wvalid  = 1'b0;
	logic [3:0]        wstrb   = 4'hF;
	logic              wready;
	logic [1:0]        bresp;
	logic              bvalid;
	logic              bready  = 1'b0;
	logic [ADDR_W-1:0] araddr  = '0;
	logic              arvalid = 1'b0;
	logic              arready;
	logic [31:0]       rdata;
	logic [1:0]        rresp;
	logic              rvalid;
	logic              rready  = 1'b0;
	logic              ext_a;
	logic              ext_b;
	logic [NUM_TTL-1:0] ttl;
	logic [NUM_CH-1:0] oc;
	logic [NUM_CH-1:0] cmp;
	tco_drive_s        drive;
	tco_bank_s         bank;
	logic [1:0]        resp;
	logic [31:0]       rdv;
	int                error_cnt       = 0;
	int                samples_checked = 0;
	tco_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .external_trigger_a(ext_a),
		.external_trigger_b(ext_b), .ttl_trig(ttl), .oc_in(oc), .cmp_in(cmp),
		.drive(drive), .bank(bank));
	tco_far_model far (.aclk(aclk), .external_trigger_a(ext_a), .external_trigger_b(ext_b),
		.ttl_trig(ttl), .oc_in(oc), .cmp_in(cmp));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic print_verdict();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic hang();
		error_cnt++;
		$display("BAD wait expected answer seen timeout");
		print_verdict();
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) break;
		end
		if (n == 100) hang();
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) break;
		end
		if (n == 100) hang();
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
		chk("rdata", d, exp);
	endtask
	task automatic pulse_ttl(input logic [7:0] v);
		far.set_ttl(v);
		tick(8);
		far.set_ttl(8'h00);
		tick(8);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge aclk);
		hang();
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(OFF_CTRL, CTRL_RST);
		rc(OFF_BANKV, 32'h0000_0000);
		rc(OFF_DAC, 32'h0000_0000);
		chk("drive_on", drive.on[31:0], 32'h0000_0000);
		// direct mode: enable and level apply at once
		w(OFF_ENA, 32'h0000_1001);
		w(OFF_LVL, 32'h0000_0001);
		tick(1);
		chk("drive_on", drive.on[31:0], 32'h0000_1001);
		chk("drive_high", drive.high[31:0], 32'h0000_0001);
		rc(OFF_ACT, 32'h0000_1001);
		w(OFF_BANKV, 32'h0000_0002);
		tick(1);
		chk("bank_hv", {22'h0, bank.hv}, 32'h0000_0002);
		chk("hv_bank2", {20'h0, drive.hv[23:12]}, 32'h0000_0FFF);
		chk("hv_edges", {30'h0, drive.hv[24], drive.hv[11]}, 32'h0000_0000);
		w(OFF_DAC + 8'h24, 32'hFFFF_FFFF);
		rc(OFF_DAC + 8'h24, {20'h0, DAC_FULL});
		chk("dac10", {20'h0, bank.dac[9]}, {20'h0, DAC_FULL});
		// only the strobed byte lands
		wstrb <= 4'h2;
		w(OFF_DAC, 32'h0000_0A55);
		wstrb <= 4'hF;
		rc(OFF_DAC, 32'h0000_0A00);
		wr(8'h60, 32'h0000_0001, resp);
		chk("bresp_unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
		rd(8'h60, rdv, resp);
		chk("rresp_unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
		far.set_cmp({88'h0, 32'hA5A5_0F0F});
		tick(6);
		rc(OFF_RDB, 32'hA5A5_0F0F);
		// over-current shuts channel 1 and latches its event
		far.set_oc({119'h0, 1'b1});
		tick(8);
		chk("oc_off", {31'h0, drive.on[0]}, 32'h0000_0000);
		rc(OFF_OCS, 32'h0000_0001);
		far.set_oc('0);
		tick(6);
		rc(OFF_OCS, 32'h0000_0001);
		w(OFF_OCS, 32'h0000_0001);
		rc(OFF_OCS, 32'h0000_0000);
		rc(OFF_ENA, 32'h0000_1000);
		// software trigger
		w(OFF_CTRL, 32'h0000_0021);
		w(OFF_ENA + 8'h04, 32'h0000_0001);
		w(OFF_LVL + 8'h04, 32'h0000_0001);
		w(OFF_BANKV, 32'h0000_0200);
		tick(4);
		chk("held", {30'h0, drive.on[32], drive.high[32]}, 32'h0000_0000);
		chk("bankv_now", {22'h0, bank.hv}, 32'h0000_0200);
		w(OFF_CTRL, 32'h8000_0021);
		tick(1);
		chk("sw_fire", {30'h0, drive.on[32], drive.high[32]}, 32'h0000_0003);
		rc(OFF_CTRL, 32'h0000_0021);
		// external AND then OR
		w(OFF_CTRL, 32'h0000_0007);
		w(OFF_ENA + 8'h08, 32'h0000_0001);
		far.set_ext(1'b1, 1'b0);
		tick(12);
		chk("and_one", {31'h0, drive.on[64]}, 32'h0000_0000);
		far.set_ext(1'b1, 1'b1);
		tick(12);
		chk("and_both", {31'h0, drive.on[64]}, 32'h0000_0001);
		far.set_ext(1'b0, 1'b0);
		tick(12);
		w(OFF_CTRL, 32'h0000_0003);
		w(OFF_ENA + 8'h08, 32'h0000_0000);
		tick(4);
		chk("or_none", {31'h0, drive.on[64]}, 32'h0000_0001);
		far.set_ext(1'b0, 1'b1);
		tick(12);
		chk("or_one", {31'h0, drive.on[64]}, 32'h0000_0000);
		w(OFF_ENA + 8'h08, 32'h0000_0001);
		tick(2);
		chk("level", {31'h0, drive.on[64]}, 32'h0000_0001);
		far.set_ext(1'b0, 1'b0);
		tick(12);
		// external outranks backplane and software
		w(OFF_CTRL, 32'h0000_FF3B);
		w(OFF_ENA + 8'h08, 32'h0000_0000);
		pulse_ttl(8'hFF);
		chk("ttl_ignored", {31'h0, drive.on[64]}, 32'h0000_0001);
		w(OFF_CTRL, 32'h8000_FF3B);
		tick(2);
		chk("sw_ignored", {31'h0, drive.on[64]}, 32'h0000_0001);
		// backplane edges on line 3 only
		w(OFF_CTRL, 32'h0000_0819);
		w(OFF_ENA + 8'h0C, 32'hFFFF_FFFF);
		rc(OFF_ENA + 8'h0C, TOP_MASK);
		pulse_ttl(8'h04);
		chk("ttl_masked", {8'h0, drive.on[119:96]}, 32'h0000_0000);
		far.set_ttl(8'h08);
		tick(8);
		chk("ttl_rise", {8'h0, drive.on[119:96]}, TOP_MASK);
		w(OFF_CTRL, 32'h0000_0809);
		w(OFF_ENA + 8'h0C, 32'h0000_0000);
		tick(4);
		chk("no_edge", {8'h0, drive.on[119:96]}, TOP_MASK);
		far.set_ttl(8'h00);
		tick(8);
		chk("ttl_fall", {8'h0, drive.on[119:96]}, 32'h0000_0000);
		// reset in mid-run brings settings back to their reset values
		aresetn <= 1'b0;
		tick(2);
		aresetn <= 1'b1;
		rc(OFF_BANKV, 32'h0000_0000);
		rc(OFF_DAC + 8'h24, 32'h0000_0000);
		chk("bank_hv_rst", {22'h0, bank.hv}, 32'h0000_0000);
		print_verdict();
	end
endmodule
`default_nettype wire
